// ==== hdl/usb_endpoint_mode_responder.sv ====
// Top of the endpoint mode responder: token answers and automatic mode changes.
// Assumes tokens arrive as single-cycle requests already parsed from the bus.
//
// Function
// - Both endpoints each have their own mode.
// - 0011 stalls IN/OUT; 0100 ignores them.
// - Mode 0000 ignores all tokens silently.
// - Mode 0001 accepts SETUP, NAKs IN and OUT.
// - Control SETUP ACK forces mode 0001 unless disabled.
// - 1011 NAKs IN, ACKs OUT, then becomes 0001.
// - Status modes 0010, 0110, 1010 behave per table.
// - Checked OUT ACKs only zero-length DATA1 packets.
// - Counted IN sends the count register bytes.
// - 1000 NAKs OUT; 1001 ACKs OUT, becomes 1000.
// - Data endpoint bit 7 stalls 1001/1101 traffic.
// - 1100 NAKs IN; 1101 sends data, becomes 1100.
// - 1110 NAKs IN; 1111 sends data, becomes 1110.
// - Modes reset to 0000 and stay until written.
// - ACK locks mode/count writes until a later read.
// - Only valid packets up to size plus two answered.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module usb_endpoint_mode_responder
    import ep_mode_pkg::*;
#(
    parameter int EP_SIZE = ENDPOINT_SIZE
)
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire ep_mode_pkg::token_req_t i_token,
    input wire logic i_host_ack,
    output ep_mode_pkg::token_rsp_t o_rsp,
    output logic [1:0] o_locked
);
    import ep_mode_pkg::*;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [31:0] rd_data;
    logic [7:0] mode0;
    logic [7:0] mode1;
    logic [3:0] count0;
    logic [3:0] count1;
    logic [1:0] locked;
    logic [1:0] hw_wr;
    logic [3:0] hw_mode;
    logic [1:0] acked;

    ep_apb_regs u_regs (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_psel(i_psel),
        .i_penable(i_penable && o_pready),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .i_hw_wr(hw_wr),
        .i_hw_mode(hw_mode),
        .i_acked(acked),
        .o_prdata(rd_data),
        .o_pslverr(),
        .o_mode0(mode0),
        .o_mode1(mode1),
        .o_count0(count0),
        .o_count1(count1),
        .o_locked(locked)
    );

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    // One wait state so that every bus output comes from a flip-flop.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && i_penable && !o_pready;
            o_prdata <= rd_data;
            o_pslverr <= i_psel && i_penable && !o_pready && (i_paddr[7:4] != 4'h0 || i_paddr[1:0] != 2'b00);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_locked <= 2'b00;
        end else begin
            o_locked <= locked;
        end
    end

    // ----------------------------------------
    // Token decode
    // ----------------------------------------
    logic [3:0] cur_mode;
    logic cur_stall;
    logic pkt_ok;
    logic zero_dtog1;
    resp_t dec_resp;

    assign cur_mode = i_token.ep ? mode1[3:0] : mode0[3:0];
    assign cur_stall = i_token.ep ? mode1[STALL_BIT] : 1'b0;
    assign pkt_ok = i_token.crc_ok && (32'(i_token.count) <= EP_SIZE + CRC_BYTES);
    assign zero_dtog1 = (i_token.count == 5'(CRC_BYTES)) && i_token.dtog;

    ep_mode_decode u_dec (
        .i_mode(cur_mode),
        .i_stall(cur_stall),
        .i_token(i_token.token),
        .i_zero_dtog1(zero_dtog1),
        .o_resp(dec_resp)
    );

    // ----------------------------------------
    // Answer register and pending IN
    // ----------------------------------------
    logic in_pending;
    logic in_ep;
    logic [3:0] in_mode;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rsp <= '{valid: 1'b0, ep: 1'b0, resp: RSP_IGNORE, count: 4'h0};
        end else begin
            o_rsp.valid <= i_token.valid && pkt_ok && dec_resp != RSP_IGNORE;
            o_rsp.ep <= i_token.ep;
            o_rsp.resp <= pkt_ok ? dec_resp : RSP_IGNORE;
            o_rsp.count <= (dec_resp == RSP_TX_COUNT) ? (i_token.ep ? count1 : count0) : 4'h0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            in_pending <= 1'b0;
            in_ep <= 1'b0;
            in_mode <= MODE_DISABLE;
        end else if (i_token.valid) begin
            in_pending <= pkt_ok && (dec_resp == RSP_TX_COUNT || dec_resp == RSP_TX_ZERO);
            in_ep <= i_token.ep;
            in_mode <= cur_mode;
        end else if (i_host_ack) begin
            in_pending <= 1'b0;
        end
    end

    // ----------------------------------------
    // Automatic mode rewrites
    // ----------------------------------------
    logic dev_ack;
    assign dev_ack = i_token.valid && pkt_ok && dec_resp == RSP_ACK;

    always_comb begin
        hw_wr = 2'b00;
        hw_mode = MODE_NAK_INOUT;
        acked = 2'b00;
        if (dev_ack) begin
            acked[i_token.ep] = 1'b1;
            if (i_token.token == TOK_SETUP && !i_token.ep && cur_mode != MODE_DISABLE) begin
                hw_wr[0] = 1'b1;
                hw_mode = MODE_NAK_INOUT;
            end else if (i_token.token == TOK_OUT && cur_mode == MODE_ACK_OUT_NAK_IN) begin
                hw_wr[i_token.ep] = 1'b1;
                hw_mode = MODE_NAK_INOUT;
            end else if (i_token.token == TOK_OUT && cur_mode == MODE_ACK_OUT) begin
                hw_wr[i_token.ep] = 1'b1;
                hw_mode = MODE_NAK_OUT;
            end else if (i_token.token == TOK_OUT && cur_mode == MODE_ACK_IN_STOUT) begin
                hw_wr[i_token.ep] = 1'b1;
                hw_mode = MODE_NAK_IN_STOUT;
            end
        end else if (i_host_ack && in_pending && !i_token.valid) begin
            acked[in_ep] = 1'b1;
            if (in_mode == MODE_ACK_IN) begin
                hw_wr[in_ep] = 1'b1;
                hw_mode = MODE_NAK_IN;
            end else if (in_mode == MODE_ACK_IN_STOUT) begin
                hw_wr[in_ep] = 1'b1;
                hw_mode = MODE_NAK_IN_STOUT;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_disabled_tok;
        i_token.valid && cur_mode == MODE_DISABLE;
    endsequence

    a_disabled_silent: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        s_disabled_tok |=> !o_rsp.valid) else $error("Disabled endpoint answered.");

    a_nak_mode_one: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_token.valid && pkt_ok && cur_mode == MODE_NAK_INOUT && i_token.token != TOK_SETUP
        |=> o_rsp.valid && o_rsp.resp == RSP_NAK) else $error("Mode 0001 did not NAK.");

    a_stall_mode: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_token.valid && pkt_ok && cur_mode == MODE_STALL_INOUT && i_token.token != TOK_SETUP
        |=> o_rsp.resp == RSP_STALL) else $error("Mode 0011 did not stall.");

    a_setup_rewrite: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        dev_ack && i_token.token == TOK_SETUP && !i_token.ep && cur_mode != MODE_DISABLE
        |=> mode0[3:0] == MODE_NAK_INOUT) else $error("Setup did not force mode 0001.");

    a_ack_out_rewrite: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        dev_ack && i_token.token == TOK_OUT && i_token.ep && mode1[3:0] == MODE_ACK_OUT
        |=> mode1[3:0] == MODE_NAK_OUT) else $error("Mode 1001 did not become 1000.");

    a_check_out: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_token.valid && pkt_ok && i_token.token == TOK_OUT && cur_mode == MODE_STATUS_OUT && !zero_dtog1
        |=> o_rsp.resp != RSP_ACK) else $error("Checked OUT acked a bad packet.");

    a_tx_count: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_token.valid && pkt_ok && dec_resp == RSP_TX_COUNT
        |=> o_rsp.count == $past(i_token.ep ? count1 : count0)) else $error("Wrong IN byte count.");

    a_stall_flag: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_token.valid && pkt_ok && i_token.ep && mode1[STALL_BIT] && mode1[3:0] == MODE_ACK_IN
        && i_token.token == TOK_IN |=> o_rsp.resp == RSP_STALL) else $error("Stall flag ignored.");

    a_invalid_drop: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        i_token.valid && !pkt_ok |=> !o_rsp.valid) else $error("Invalid packet answered.");

    a_lock_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        locked[0] && i_psel && i_penable && i_pwrite && !hw_wr[0]
        |=> mode0 == $past(mode0)) else $error("Locked mode register changed.");
endmodule : usb_endpoint_mode_responder

// ==== hdl/ep_mode_pkg.sv ====
// Package for the endpoint mode responder: mode codes, register map, carriers.
// Assumes one 125 MHz clock and an APB register bus with 32-bit data.
package ep_mode_pkg;

    // ----------------------------------------
    // Mode encodings
    // ----------------------------------------
    localparam logic [3:0] MODE_DISABLE = 4'h0;
    localparam logic [3:0] MODE_NAK_INOUT = 4'h1;
    localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
    localparam logic [3:0] MODE_STALL_INOUT = 4'h3;
    localparam logic [3:0] MODE_IGNORE_INOUT = 4'h4;
    localparam logic [3:0] MODE_STATUS_IN = 4'h6;
    localparam logic [3:0] MODE_NAK_OUT = 4'h8;
    localparam logic [3:0] MODE_ACK_OUT = 4'h9;
    localparam logic [3:0] MODE_NAK_OUT_STIN = 4'ha;
    localparam logic [3:0] MODE_ACK_OUT_NAK_IN = 4'hb;
    localparam logic [3:0] MODE_NAK_IN = 4'hc;
    localparam logic [3:0] MODE_ACK_IN = 4'hd;
    localparam logic [3:0] MODE_NAK_IN_STOUT = 4'he;
    localparam logic [3:0] MODE_ACK_IN_STOUT = 4'hf;

    // ----------------------------------------
    // Register map and fields
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTL_MODE = 8'h00;
    localparam logic [7:0] ADDR_CTL_COUNT = 8'h04;
    localparam logic [7:0] ADDR_DATA_MODE = 8'h08;
    localparam logic [7:0] ADDR_DATA_COUNT = 8'h0c;
    localparam int STALL_BIT = 7;
    localparam logic [7:0] MODE_REG_RESET = 8'h00;
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam int ENDPOINT_SIZE = 8;
    localparam int CRC_BYTES = 2;

    // ----------------------------------------
    // Tokens and answers
    // ----------------------------------------
    typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT} token_t;
    typedef enum logic [2:0] {RSP_IGNORE, RSP_ACK, RSP_NAK, RSP_STALL, RSP_TX_ZERO, RSP_TX_COUNT} resp_t;

    typedef struct packed {
        logic valid;
        logic ep;
        token_t token;
        logic [4:0] count;
        logic dtog;
        logic crc_ok;
    } token_req_t;

    typedef struct packed {
        logic valid;
        logic ep;
        resp_t resp;
        logic [3:0] count;
    } token_rsp_t;

endpackage : ep_mode_pkg

// ==== hdl/ep_mode_decode.sv ====
// Combinational decoder from endpoint mode and token to an answer.
// Assumes the caller has already checked packet validity.
`timescale 1ns/1ps
module ep_mode_decode
    import ep_mode_pkg::*;
(
    input wire logic [3:0] i_mode,
    input wire logic i_stall,
    input wire ep_mode_pkg::token_t i_token,
    input wire logic i_zero_dtog1,
    output ep_mode_pkg::resp_t o_resp
);
    always_comb begin
        o_resp = RSP_IGNORE;
        unique case (i_token)
            TOK_SETUP: begin
                if (i_mode inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'ha, 4'hb, 4'he, 4'hf}) begin
                    o_resp = RSP_ACK;
                end
            end
            TOK_IN: begin
                case (i_mode)
                    MODE_NAK_INOUT, MODE_ACK_OUT_NAK_IN, MODE_NAK_IN, MODE_NAK_IN_STOUT: o_resp = RSP_NAK;
                    MODE_STATUS_OUT, MODE_STALL_INOUT: o_resp = RSP_STALL;
                    MODE_STATUS_IN, MODE_NAK_OUT_STIN: o_resp = RSP_TX_ZERO;
                    MODE_ACK_IN: o_resp = i_stall ? RSP_STALL : RSP_TX_COUNT;
                    MODE_ACK_IN_STOUT: o_resp = RSP_TX_COUNT;
                    default: o_resp = RSP_IGNORE;
                endcase
            end
            TOK_OUT: begin
                case (i_mode)
                    MODE_NAK_INOUT, MODE_NAK_OUT, MODE_NAK_OUT_STIN: o_resp = RSP_NAK;
                    MODE_STALL_INOUT, MODE_STATUS_IN: o_resp = RSP_STALL;
                    MODE_ACK_OUT: o_resp = i_stall ? RSP_STALL : RSP_ACK;
                    MODE_ACK_OUT_NAK_IN: o_resp = RSP_ACK;
                    MODE_STATUS_OUT, MODE_NAK_IN_STOUT, MODE_ACK_IN_STOUT: begin
                        o_resp = i_zero_dtog1 ? RSP_ACK : RSP_STALL;
                    end
                    default: o_resp = RSP_IGNORE;
                endcase
            end
            default: o_resp = RSP_IGNORE;
        endcase
    end
endmodule : ep_mode_decode

// ==== hdl/ep_apb_regs.sv ====
// APB slave holding mode and count registers for both endpoints.
// Assumes the engine reports mode rewrites and ACKed transactions per endpoint.
`timescale 1ns/1ps
module ep_apb_regs
    import ep_mode_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [1:0] i_hw_wr,
    input wire logic [3:0] i_hw_mode,
    input wire logic [1:0] i_acked,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    output logic [7:0] o_mode0,
    output logic [7:0] o_mode1,
    output logic [3:0] o_count0,
    output logic [3:0] o_count1,
    output logic [1:0] o_locked
);
    logic access;
    logic [1:0] sel_ep;
    logic sel_count;
    logic mapped;
    assign access = i_psel && i_penable;
    assign sel_ep = {1'b0, i_paddr[3]};
    assign sel_count = i_paddr[2];
    assign mapped = (i_paddr[7:4] == 4'h0) && (i_paddr[1:0] == 2'b00);

    // ----------------------------------------
    // Lock: set by ACK, released by a later read
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_locked <= 2'b00;
        end else begin
            for (int e = 0; e < 2; e++) begin
                if (i_acked[e]) begin
                    o_locked[e] <= 1'b1;
                end else if (access && !i_pwrite && mapped && sel_ep[0] == e[0]) begin
                    o_locked[e] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_mode0 <= MODE_REG_RESET;
            o_mode1 <= MODE_REG_RESET;
            o_count0 <= COUNT_RESET;
            o_count1 <= COUNT_RESET;
        end else begin
            if (access && i_pwrite && mapped && !o_locked[sel_ep[0]]) begin
                unique case ({sel_ep[0], sel_count})
                    2'b00: o_mode0 <= {4'h0, i_pwdata[3:0]};
                    2'b01: o_count0 <= i_pwdata[3:0];
                    2'b10: o_mode1 <= {i_pwdata[STALL_BIT], 3'b000, i_pwdata[3:0]};
                    2'b11: o_count1 <= i_pwdata[3:0];
                endcase
            end
            // The engine's rewrite lands after any CPU write in the same cycle.
            if (i_hw_wr[0]) begin
                o_mode0[3:0] <= i_hw_mode;
            end
            if (i_hw_wr[1]) begin
                o_mode1[3:0] <= i_hw_mode;
            end
        end
    end

    always_comb begin
        o_prdata = 32'h0000_0000;
        o_pslverr = access && !mapped;
        if (mapped) begin
            unique case ({sel_ep[0], sel_count})
                2'b00: o_prdata = {24'h00_0000, o_mode0};
                2'b01: o_prdata = {28'h000_0000, o_count0};
                2'b10: o_prdata = {24'h00_0000, o_mode1};
                2'b11: o_prdata = {28'h000_0000, o_count1};
            endcase
        end
    end
endmodule : ep_apb_regs

// ==== dv/usb_host_model.sv ====
// Host model that issues single-cycle tokens to the endpoint responder.
// Assumes the responder answers one cycle after the token edge.
`timescale 1ns/1ps
module usb_host_model
    import ep_mode_pkg::*;
(
    input wire logic i_sys_clk,
    input wire ep_mode_pkg::token_rsp_t i_rsp,
    output ep_mode_pkg::token_req_t o_token,
    output logic o_host_ack
);
    // ----------------------------------------
    // Token issue and handshake
    // ----------------------------------------
    int ack_delay = 0;

    initial begin
        o_token = '0;
        o_host_ack = 1'b0;
    end

    // Released token fields are inverted so that stale values never look valid.
    task automatic send(input logic ep, input token_t tk, input logic [4:0] cnt, input logic dtog,
                        input logic crc, output token_rsp_t rsp);
        token_req_t t;
        @(posedge i_sys_clk);
        o_token <= '{valid: 1'b1, ep: ep, token: tk, count: cnt, dtog: dtog, crc_ok: crc};
        @(posedge i_sys_clk);
        t = token_req_t'(~o_token);
        t.valid = 1'b0;
        o_token <= t;
        @(posedge i_sys_clk);
        rsp = i_rsp;
        if (rsp.valid === 1'b1 && (rsp.resp === RSP_TX_ZERO || rsp.resp === RSP_TX_COUNT)) begin
            repeat (ack_delay) @(posedge i_sys_clk);
            o_host_ack <= 1'b1;
            @(posedge i_sys_clk);
            o_host_ack <= 1'b0;
        end
        // The lock output is registered one edge after the ack edge, so let it settle first.
        repeat (2) @(posedge i_sys_clk);
    endtask : send
endmodule : usb_host_model

// ==== dv/usb_endpoint_mode_responder_bench.sv ====
// Self-checking bench for the endpoint mode responder.
// Assumes the host model drives tokens and this bench is the APB master.
`timescale 1ns/1ps
module usb_endpoint_mode_responder_bench;
    import ep_mode_pkg::*;
    // ----------------------------------------
    // Signals, clock and instances
    // ----------------------------------------
    localparam int EPS = 8;
    localparam int LIMIT = 20000;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    token_req_t token;
    logic host_ack;
    token_rsp_t rsp;
    logic [1:0] locked;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #4 i_sys_clk = ~i_sys_clk;

    usb_endpoint_mode_responder #(.EP_SIZE(EPS)) uut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_token(token), .i_host_ack(host_ack), .o_rsp(rsp),
        .o_locked(locked));
    usb_host_model host (.i_sys_clk(i_sys_clk), .i_rsp(rsp), .o_token(token), .o_host_ack(host_ack));

    task automatic results;
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge i_sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do @(posedge i_sys_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd

    task automatic do_reset;
        @(posedge i_sys_clk);
        i_nrst <= 1'b0;
        repeat (20) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
    endtask : do_reset

    // ----------------------------------------
    // Expected answers
    // ----------------------------------------
    function automatic resp_t exp_rsp(input logic [3:0] m, input logic st, input token_t tk, input logic ok);
        resp_t r[3];
        resp_t ck;
        ck = ok ? RSP_ACK : RSP_STALL;
        case (m)
            4'h1: r = '{RSP_ACK, RSP_NAK, RSP_NAK};
            4'h2: r = '{RSP_ACK, RSP_STALL, ck};
            4'h3: r = '{RSP_ACK, RSP_STALL, RSP_STALL};
            4'h4: r = '{RSP_ACK, RSP_IGNORE, RSP_IGNORE};
            4'h6: r = '{RSP_ACK, RSP_TX_ZERO, RSP_STALL};
            4'h8: r = '{RSP_IGNORE, RSP_IGNORE, RSP_NAK};
            4'h9: r = '{RSP_IGNORE, RSP_IGNORE, st ? RSP_STALL : RSP_ACK};
            4'ha: r = '{RSP_ACK, RSP_TX_ZERO, RSP_NAK};
            4'hb: r = '{RSP_ACK, RSP_NAK, RSP_ACK};
            4'hc: r = '{RSP_IGNORE, RSP_NAK, RSP_IGNORE};
            4'hd: r = '{RSP_IGNORE, st ? RSP_STALL : RSP_TX_COUNT, RSP_IGNORE};
            4'he: r = '{RSP_ACK, RSP_NAK, ck};
            4'hf: r = '{RSP_ACK, RSP_TX_COUNT, ck};
            default: r = '{RSP_IGNORE, RSP_IGNORE, RSP_IGNORE};
        endcase
        return r[int'(tk)];
    endfunction : exp_rsp

    function automatic logic [3:0] exp_mode(input logic [3:0] m, input logic ep, input token_t tk, input resp_t r);
        if (r == RSP_ACK && tk == TOK_SETUP && !ep && m != 4'h0) return 4'h1;
        if (r == RSP_ACK && tk == TOK_OUT && m == 4'hb) return 4'h1;
        if (r == RSP_ACK && tk == TOK_OUT && m == 4'h9) return 4'h8;
        if ((r == RSP_TX_COUNT || r == RSP_ACK) && m == 4'hf) return 4'he;
        if (r == RSP_TX_COUNT && m == 4'hd) return 4'hc;
        return m;
    endfunction : exp_mode

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reading first releases this endpoint's lock left by an earlier transaction; the other endpoint's lock is kept.
    task automatic tcase(input logic ep, input logic [3:0] m, input logic st, input token_t tk,
                         input logic [4:0] cnt, input logic dtog, input logic crc);
        logic [31:0] r;
        token_rsp_t got;
        resp_t want;
        logic tx;
        rd(ep ? ADDR_DATA_MODE : ADDR_CTL_MODE, r);
        wr(ep ? ADDR_DATA_COUNT : ADDR_CTL_COUNT, {28'h0, m});
        wr(ep ? ADDR_DATA_MODE : ADDR_CTL_MODE, {24'h0, st, 3'h0, m});
        host.send(ep, tk, cnt, dtog, crc, got);
        want = exp_rsp(m, st, tk, cnt == 5'd2 && dtog);
        if (cnt > 5'(EPS + CRC_BYTES) || !crc) want = RSP_IGNORE;
        tx = want == RSP_TX_COUNT || want == RSP_TX_ZERO;
        check(32'(got.valid), 32'(want != RSP_IGNORE), "answer valid");
        if (want != RSP_IGNORE) begin
            check(32'(got.ep), 32'(ep), "answer endpoint");
            check(32'(got.resp), 32'(want), "answer kind");
        end
        if (tx) check(32'(got.count), want == RSP_TX_COUNT ? 32'(m) : 32'h0, "byte count");
        check(32'(locked[ep]), 32'(want == RSP_ACK || tx), "write lock");
        rd(ep ? ADDR_DATA_MODE : ADDR_CTL_MODE, r);
        check(r, {24'h0, st, 3'h0, exp_mode(m, ep, tk, want)}, "mode after");
    endtask : tcase

    task automatic reset_state;
        logic [31:0] r;
        logic e;
        token_rsp_t got;
        for (int a = 0; a < 4; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0, r, e);
            check(r, 32'h0, "reset value");
            check(32'(e), 32'h0, "mapped error");
        end
        apb(1'b0, 8'h10, 32'h0, r, e);
        check(32'(e), 32'h1, "unmapped error");
        check(r, 32'h0, "unmapped data");
        for (int t = 0; t < 3; t++) begin
            host.send(t[0], token_t'(t), 5'd2, 1'b1, 1'b1, got);
            check(32'(got.valid), 32'h0, "disabled answer");
        end
        check(32'(locked), 32'h0, "reset lock");
    endtask : reset_state

    task automatic control_modes;
        for (int m = 0; m < 16; m++) begin
            if (m == 5 || m == 7) continue;
            for (int t = 0; t < 3; t++) tcase(1'b0, 4'(m), 1'b0, token_t'(t), 5'd2, 1'b1, 1'b1);
        end
    endtask : control_modes

    // The slow host acknowledge here exercises a late handshake.
    task automatic data_modes;
        logic [3:0] modes [5] = '{4'h0, 4'h8, 4'h9, 4'hc, 4'hd};
        host.ack_delay = 4;
        foreach (modes[i]) for (int s = 0; s < 2; s++) begin
            tcase(1'b1, modes[i], s[0], TOK_IN, 5'd6, 1'b0, 1'b1);
            tcase(1'b1, modes[i], s[0], TOK_OUT, 5'd6, 1'b0, 1'b1);
        end
        host.ack_delay = 0;
    endtask : data_modes

    task automatic odd_packets;
        tcase(1'b0, 4'h2, 1'b0, TOK_OUT, 5'd2, 1'b0, 1'b1);
        tcase(1'b0, 4'he, 1'b0, TOK_OUT, 5'd3, 1'b1, 1'b1);
        tcase(1'b0, 4'hf, 1'b0, TOK_OUT, 5'd2, 1'b1, 1'b1);
        tcase(1'b1, 4'h9, 1'b0, TOK_OUT, 5'(EPS + CRC_BYTES), 1'b0, 1'b1);
        tcase(1'b1, 4'h9, 1'b0, TOK_OUT, 5'(EPS + CRC_BYTES + 1), 1'b0, 1'b1);
        tcase(1'b0, 4'h1, 1'b0, TOK_SETUP, 5'd10, 1'b0, 1'b0);
    endtask : odd_packets

    task automatic write_lock;
        logic [31:0] r;
        token_rsp_t got;
        rd(ADDR_CTL_MODE, r);
        wr(ADDR_CTL_COUNT, 32'h2);
        wr(ADDR_CTL_MODE, 32'h1);
        host.send(1'b0, TOK_SETUP, 5'd10, 1'b0, 1'b1, got);
        check(32'(locked), 32'h1, "lock after ack");
        wr(ADDR_CTL_MODE, 32'h3);
        wr(ADDR_CTL_COUNT, 32'h7);
        wr(ADDR_DATA_MODE, 32'h8);
        rd(ADDR_DATA_MODE, r);
        check(r, 32'h8, "other endpoint free");
        check(32'(locked), 32'h1, "lock held");
        rd(ADDR_CTL_COUNT, r);
        check(r, 32'h2, "locked count kept");
        // The lock clears at the read's edge and reaches the output one edge later.
        repeat (2) @(posedge i_sys_clk);
        check(32'(locked), 32'h0, "lock released");
        wr(ADDR_CTL_MODE, 32'h3);
        rd(ADDR_CTL_MODE, r);
        check(r, 32'h3, "write after release");
    endtask : write_lock

    task automatic mid_reset;
        logic [31:0] r;
        wr(ADDR_DATA_MODE, 32'h8d);
        do_reset();
        rd(ADDR_CTL_MODE, r);
        check(r, 32'h0, "control mode reset");
        rd(ADDR_DATA_MODE, r);
        check(r, 32'h0, "data mode reset");
    endtask : mid_reset

    initial begin
        do_reset();
        reset_state();
        control_modes();
        data_modes();
        odd_packets();
        write_lock();
        mid_reset();
        results();
    end
endmodule : usb_endpoint_mode_responder_bench
